// ==== ttfr_fault_resp.sv ====
/*
 * Temperature limit registers and under-temperature fault response.
 * Holds the four limit/response registers reached by command code,
 * compares the measured temperature and runs the fault response.
 * Assumes the bus protocol engine delivers decoded one-cycle requests
 * on clk, and that temperature and limits share one numeric coding
 * (compared as signed 16-bit). The control pin arrives asynchronously.
 */
`timescale 1ns/100ps
module ttfr_fault_resp
    import ttfr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire ttfr_req_t req,
    output ttfr_rsp_t rsp,
    input wire logic [15:0] temperature,
    input wire logic [UNIT_W-1:0] unitCycles,
    input wire logic clearAll,
    input wire logic clearFaultBit,
    input wire logic clearWarnBits,
    input wire logic operationOn,
    input wire logic controlPin,
    input wire logic otherFault,
    output logic outputEnable,
    output logic utFaultFlag,
    output logic utWarnFlag,
    output logic otWarnFlag
);

    // ************************************************************
    // Registers and input synchroniser
    // ************************************************************
    logic [15:0] overTempWarn;
    logic [15:0] underTempWarn;
    logic [15:0] underTempFault;
    logic [7:0] utAction;
    logic [15:0] next_overTempWarn;
    logic [15:0] next_underTempWarn;
    logic [15:0] next_underTempFault;
    logic [7:0] next_utAction;
    ttfr_rsp_t next_rsp;
    logic pinMeta;
    logic pinSync;
    logic onPrev;
    logic onNow;
    logic reEnable;

    // Register writes and reads by command code
    always_comb begin
        next_overTempWarn = overTempWarn;
        next_underTempWarn = underTempWarn;
        next_underTempFault = underTempFault;
        next_utAction = utAction;
        next_rsp = '0;
        if (req.wr) begin
            unique case (req.cmd)
                CMD_OT_WARN: next_overTempWarn = req.wdata;
                CMD_UT_WARN: next_underTempWarn = req.wdata;
                CMD_UT_FAULT: next_underTempFault = req.wdata;
                CMD_UT_ACTION: next_utAction = req.wdata[7:0];
                default: next_rsp.unknown = 1'b1;
            endcase
        end else if (req.rd) begin
            next_rsp.rvalid = 1'b1;
            unique case (req.cmd)
                CMD_OT_WARN: next_rsp.rdata = overTempWarn;
                CMD_UT_WARN: next_rsp.rdata = underTempWarn;
                CMD_UT_FAULT: next_rsp.rdata = underTempFault;
                CMD_UT_ACTION: next_rsp.rdata = {8'h00, utAction};
                default: begin
                    next_rsp.rvalid = 1'b0;
                    next_rsp.unknown = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            overTempWarn <= OT_WARN_RESET;
            underTempWarn <= UT_WARN_RESET;
            underTempFault <= UT_FAULT_RESET;
            utAction <= UT_ACTION_RESET;
            rsp <= '0;
        end else begin
            overTempWarn <= next_overTempWarn;
            underTempWarn <= next_underTempWarn;
            underTempFault <= next_underTempFault;
            utAction <= next_utAction;
            rsp <= next_rsp;
        end
    end

    // Pin synchroniser; only pinSync feeds logic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            onPrev <= 1'b0;
        end else begin
            pinMeta <= controlPin;
            pinSync <= pinMeta;
            onPrev <= onNow;
        end
    end

    // Output commanded on by pin and OPERATION together
    assign onNow = pinSync & operationOn;
    assign reEnable = onNow & ~onPrev;

    // ************************************************************
    // Limit comparison
    // ************************************************************
    logic faultNow;
    logic utWarnNow;
    logic otWarnNow;
    logic next_utWarnFlag;
    logic next_otWarnFlag;

    // Signed compare; limits in same coding as temperature
    assign faultNow = $signed(temperature) < $signed(underTempFault);
    assign utWarnNow = $signed(temperature) < $signed(underTempWarn);
    assign otWarnNow = $signed(temperature) > $signed(overTempWarn);

    // Sticky warnings; set wins over clear. No effect on output
    always_comb begin
        next_utWarnFlag = utWarnFlag;
        next_otWarnFlag = otWarnFlag;
        if (clearAll || clearWarnBits) begin
            next_utWarnFlag = 1'b0;
            next_otWarnFlag = 1'b0;
        end
        if (utWarnNow) begin
            next_utWarnFlag = 1'b1;
        end
        if (otWarnNow) begin
            next_otWarnFlag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            utWarnFlag <= 1'b0;
            otWarnFlag <= 1'b0;
        end else begin
            utWarnFlag <= next_utWarnFlag;
            otWarnFlag <= next_otWarnFlag;
        end
    end

    // ************************************************************
    // Fault response state machine
    // ************************************************************
    ttfr_state_t state;
    ttfr_state_t next_state;
    logic [2:0] triesLeft;
    logic [2:0] next_triesLeft;
    logic next_outputEnable;
    logic next_utFaultFlag;
    logic timerStart;
    logic timerAbort;
    logic timerDone;
    logic clearEvent;
    logic [1:0] respMode;
    logic [2:0] retrySet;
    logic [DLY_W-1:0] delayUnits;

    assign respMode = utAction[RESP_HI:RESP_LO];
    assign retrySet = utAction[RETRY_HI:RETRY_LO];
    assign delayUnits = ttfr_units(utAction[DELAY_HI:DELAY_LO]);
    // Status bit clear, clear-all, or off-then-on
    assign clearEvent = clearFaultBit | clearAll | reEnable;

    ttfr_timer u_timer (
        .clk(clk),
        .rstn(rstn),
        .start(timerStart),
        .abort(timerAbort),
        .units(delayUnits),
        .unitCycles(unitCycles),
        .done(timerDone)
    );

    // Response sequencing; a new fault while clearing re-latches
    always_comb begin
        next_state = state;
        next_triesLeft = triesLeft;
        next_outputEnable = outputEnable;
        next_utFaultFlag = utFaultFlag;
        timerStart = 1'b0;
        timerAbort = 1'b0;
        if (clearEvent) begin
            next_utFaultFlag = 1'b0;
        end
        if (faultNow) begin
            next_utFaultFlag = 1'b1;
        end
        unique case (state)
            ST_RUN: begin
                next_outputEnable = 1'b1;
                next_triesLeft = retrySet;
                if (faultNow) begin
                    unique case (respMode)
                        RESP_IGNORE: next_outputEnable = 1'b1;
                        RESP_CONTINUE: begin
                            timerStart = 1'b1;
                            next_state = ST_GRACE;
                        end
                        RESP_RETRY: begin
                            next_outputEnable = 1'b0;
                            timerStart = 1'b1;
                            next_state = (retrySet == RETRY_NONE) ?
                                ST_LOCKED : ST_WAIT;
                        end
                        RESP_LATCH: begin
                            next_outputEnable = 1'b0;
                            next_state = ST_LOCKED;
                        end
                    endcase
                end
            end
            ST_GRACE: begin
                if (timerDone) begin
                    if (!faultNow) begin
                        next_state = ST_RUN;
                    end else if (retrySet == RETRY_NONE) begin
                        next_outputEnable = 1'b0;
                        next_state = ST_LOCKED;
                    end else begin
                        next_outputEnable = 1'b0;
                        timerStart = 1'b1;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (timerDone) begin
                    // Restart attempt; spacing runs start to start
                    next_outputEnable = 1'b1;
                    timerStart = 1'b1;
                    if (triesLeft != RETRY_ENDLESS) begin
                        next_triesLeft = triesLeft - 3'h1;
                    end
                    next_state = ST_RESTART;
                end
            end
            ST_RESTART: begin
                if (!faultNow && timerDone) begin
                    next_state = ST_RUN; // Restart held for full spacing
                end else if (faultNow) begin
                    next_outputEnable = 1'b0;
                    if (triesLeft == RETRY_NONE) begin
                        timerAbort = 1'b1;
                        next_state = ST_LOCKED;
                    end else begin
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_LOCKED: begin
                next_outputEnable = 1'b0;
                if (clearEvent) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_LOCKED;
        endcase
        // Commanded off ends any retry sequence
        if (!onNow && state != ST_RUN) begin
            timerAbort = 1'b1;
            next_outputEnable = 1'b0;
            next_state = ST_LOCKED;
        end else if (otherFault) begin
            timerAbort = 1'b1;
            next_outputEnable = 1'b0;
            next_state = ST_LOCKED;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_RUN;
            triesLeft <= 3'h0;
            outputEnable <= 1'b0;
            utFaultFlag <= 1'b0;
        end else begin
            state <= next_state;
            triesLeft <= next_triesLeft;
            outputEnable <= next_outputEnable;
            utFaultFlag <= next_utFaultFlag;
        end
    end

endmodule : ttfr_fault_resp

// ==== ttfr_pkg.sv ====
/*
 * Package for the temperature limit and under-temperature fault response
 * block: command codes, response field layout, reset values, state codes
 * and the carrier structs shared by the main module, its checker and the host model.
 * Assumes a single 250 MHz clock domain.
 */
package ttfr_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_OT_WARN = 8'h51;
    localparam logic [7:0] CMD_UT_WARN = 8'h52;
    localparam logic [7:0] CMD_UT_FAULT = 8'h53;
    localparam logic [7:0] CMD_UT_ACTION = 8'h54;

    // ************************************************************
    // Response byte fields
    // ************************************************************
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_CONTINUE = 2'h1;
    localparam logic [1:0] RESP_RETRY = 2'h2;
    localparam logic [1:0] RESP_LATCH = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [15:0] OT_WARN_RESET = 16'h0000;
    localparam logic [15:0] UT_WARN_RESET = 16'h0000;
    localparam logic [15:0] UT_FAULT_RESET = 16'h0000;
    localparam logic [7:0] UT_ACTION_RESET = 8'h00;
    localparam int CLK_MHZ = 250;
    localparam int UNIT_W = 24;      // Width of time unit in clock cycles
    localparam int DLY_W = 8;        // Width of unit count (max 128)

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_GRACE = 3'h1,
        ST_WAIT = 3'h2,
        ST_RESTART = 3'h3,
        ST_LOCKED = 3'h4
    } ttfr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } ttfr_req_t;

    typedef struct packed {
        logic rvalid;
        logic [15:0] rdata;
        logic unknown;
    } ttfr_rsp_t;

    // Units for a 3-bit delay code: 1, 2, 4 .. 128
    function automatic logic [DLY_W-1:0] ttfr_units(input logic [2:0] code);
        ttfr_units = DLY_W'(1) << code;
    endfunction : ttfr_units

endpackage : ttfr_pkg

// ==== ttfr_timer.sv ====
/*
 * Delay timer: counts a number of time units, each unit being a number
 * of clock cycles given from outside (the time unit register).
 * Assumes start is a one-cycle pulse; a new start restarts the count.
 */
`timescale 1ns/100ps
module ttfr_timer
    import ttfr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic abort,
    input wire logic [DLY_W-1:0] units,
    input wire logic [UNIT_W-1:0] unitCycles,
    output logic done
);

    logic [UNIT_W-1:0] cyc;
    logic [UNIT_W-1:0] next_cyc;
    logic [DLY_W-1:0] left;
    logic [DLY_W-1:0] next_left;
    logic run;
    logic next_run;
    logic next_done;

    // Unit prescaler is a one-cycle tick; zero cycles treated as one
    always_comb begin
        next_cyc = cyc;
        next_left = left;
        next_run = run;
        next_done = 1'b0;
        if (abort) begin
            next_run = 1'b0;
        end else if (start) begin
            next_run = 1'b1;
            next_cyc = '0;
            next_left = units;
        end else if (run) begin
            if (cyc + UNIT_W'(1) >= unitCycles) begin
                next_cyc = '0;
                if (left <= DLY_W'(1)) begin
                    next_run = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_left = left - DLY_W'(1);
                end
            end else begin
                next_cyc = cyc + UNIT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc <= '0;
            left <= '0;
            run <= 1'b0;
            done <= 1'b0;
        end else begin
            cyc <= next_cyc;
            left <= next_left;
            run <= next_run;
            done <= next_done;
        end
    end

endmodule : ttfr_timer

// ==== ttfr_fault_props.sv ====
/* Checker for the fault response block.
   Sees only the top module ports; bound after the module. */
`timescale 1ns/100ps
module ttfr_fault_props
    import ttfr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire ttfr_req_t req,
    input wire ttfr_rsp_t rsp,
    input wire logic [15:0] temperature,
    input wire logic [UNIT_W-1:0] unitCycles,
    input wire logic clearAll,
    input wire logic clearFaultBit,
    input wire logic clearWarnBits,
    input wire logic operationOn,
    input wire logic controlPin,
    input wire logic otherFault,
    input wire logic outputEnable,
    input wire logic utFaultFlag,
    input wire logic utWarnFlag,
    input wire logic otWarnFlag
);
    logic [15:0] otLim;
    logic [15:0] utWarnLim;
    logic [15:0] utLim;
    logic [7:0] act;
    logic [15:0] rdExp;
    logic known;
    logic fltNow;
    // Shadow limits, written at the same edge as the block's own copy
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            otLim <= 16'h0000;
            utWarnLim <= 16'h0000;
            utLim <= 16'h0000;
            act <= 8'h00;
        end else if (req.wr) begin
            if (req.cmd == CMD_OT_WARN) otLim <= req.wdata;
            if (req.cmd == CMD_UT_WARN) utWarnLim <= req.wdata;
            if (req.cmd == CMD_UT_FAULT) utLim <= req.wdata;
            if (req.cmd == CMD_UT_ACTION) act <= req.wdata[7:0];
        end
    end
    // Expected read word; the response byte reads back zero-extended
    always_comb begin
        known = 1'b1;
        case (req.cmd)
            CMD_OT_WARN: rdExp = otLim;
            CMD_UT_WARN: rdExp = utWarnLim;
            CMD_UT_FAULT: rdExp = utLim;
            CMD_UT_ACTION: rdExp = {8'h00, act};
            default: begin
                rdExp = 16'h0000;
                known = 1'b0;
            end
        endcase
    end
    assign fltNow = $signed(temperature) < $signed(utLim);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Commanded on and steady through the pin synchroniser
    sequence onSteady;
        operationOn && controlPin && $past(controlPin) &&
            $past(controlPin, 2) && !otherFault;
    endsequence
    // Latched off with no clearing event now or just before
    sequence heldOff;
        !outputEnable && utFaultFlag && !operationOn && !$past(operationOn)
            && !clearAll && !clearFaultBit && !$past(clearAll)
            && !$past(clearFaultBit)
            && (act[7:6] == RESP_LATCH || act[7:3] == 5'b10000);
    endsequence

    AST_READ_ANSWER: assert property (req.rd && !req.wr && known |=>
        rsp.rvalid && rsp.rdata == $past(rdExp))
        else $error("read answer wrong");
    AST_UNKNOWN_CMD: assert property ((req.rd || req.wr) && !known |=>
        rsp.unknown && !rsp.rvalid)
        else $error("unknown code not flagged");
    AST_IGNORE_RUNS: assert property (act[7:6] == RESP_IGNORE &&
        outputEnable ##0 onSteady |=> outputEnable)
        else $error("ignored fault stopped output");
    AST_FAULT_FLAG: assert property (fltNow |=> utFaultFlag)
        else $error("fault flag not set");
    AST_UT_WARN: assert property (
        $signed(temperature) < $signed(utWarnLim) |=> utWarnFlag)
        else $error("under warning flag not set");
    AST_OT_WARN: assert property (
        $signed(temperature) > $signed(otLim) |=> otWarnFlag)
        else $error("over warning flag not set");
    AST_DISABLE_NOW: assert property (fltNow && act[7] && outputEnable
        |=> !outputEnable)
        else $error("output not disabled at once");
    AST_STAY_OFF: assert property (heldOff |=> !outputEnable)
        else $error("output left latched off state");
endmodule : ttfr_fault_props

bind ttfr_fault_resp ttfr_fault_props chk_u (.clk(clk), .rstn(rstn),
    .req(req), .rsp(rsp), .temperature(temperature),
    .unitCycles(unitCycles), .clearAll(clearAll),
    .clearFaultBit(clearFaultBit), .clearWarnBits(clearWarnBits),
    .operationOn(operationOn), .controlPin(controlPin),
    .otherFault(otherFault), .outputEnable(outputEnable),
    .utFaultFlag(utFaultFlag), .utWarnFlag(utWarnFlag),
    .otWarnFlag(otWarnFlag));

// ==== ttfr_host_model.sv ====
/* Bus host model: one register request per call.
   Assumes the block answers one cycle after it takes a request. */
`timescale 1ns/100ps
module ttfr_host_model
    import ttfr_pkg::*;
(
    input wire logic clk,
    input wire ttfr_rsp_t rsp,
    output ttfr_req_t req
);
    initial req = '0;
    // Pulse for one cycle, then leave changed data so stale values show.
    // The answer stands one cycle only, so it is taken mid-cycle after
    // the edge that took the request, before the next edge clears it.
    task automatic access(input logic wr, input logic [7:0] cmd,
        input logic [15:0] wdata, output ttfr_rsp_t seen);
        @(negedge clk);
        req <= '{wr: wr, rd: !wr, cmd: cmd, wdata: wdata};
        @(negedge clk);
        seen = rsp;
        req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: ~wdata};
    endtask : access
endmodule : ttfr_host_model

// ==== ttfr_fault_resp_tb.sv ====
/* Testbench for the fault response block.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/100ps
module ttfr_fault_resp_tb
    import ttfr_pkg::*;
;
    localparam logic [15:0] WARM = 16'h001e;
    localparam logic [15:0] COLD = 16'hfff6;
    logic clk;
    logic rstn;
    ttfr_req_t req;
    ttfr_rsp_t rsp;
    logic [15:0] temperature;
    logic [UNIT_W-1:0] unitCycles;
    logic clearAll;
    logic clearFaultBit;
    logic clearWarnBits;
    logic operationOn;
    logic controlPin;
    logic otherFault;
    logic outputEnable;
    logic utFaultFlag;
    logic utWarnFlag;
    logic otWarnFlag;
    int fails;
    int num_checks;

    ttfr_fault_resp dut_u (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp),
        .temperature(temperature), .unitCycles(unitCycles),
        .clearAll(clearAll), .clearFaultBit(clearFaultBit),
        .clearWarnBits(clearWarnBits), .operationOn(operationOn),
        .controlPin(controlPin), .otherFault(otherFault),
        .outputEnable(outputEnable), .utFaultFlag(utFaultFlag),
        .utWarnFlag(utWarnFlag), .otWarnFlag(otWarnFlag));
    ttfr_host_model host_u (.clk(clk), .rsp(rsp), .req(req));

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic setAct(input logic [7:0] v);
        ttfr_rsp_t r;
        host_u.access(1'b1, CMD_UT_ACTION, {8'h00, v}, r);
    endtask : setAct
    // Bounded wait for the output to come on; n is cycles waited
    task automatic nextRise(output int n);
        logic prev;
        prev = outputEnable;
        for (n = 1; n <= 2000; n++) begin
            @(negedge clk);
            if (!prev && outputEnable) return;
            prev = outputEnable;
        end
        fails++;
        summarize();
    endtask : nextRise
    task automatic countRises(input int win, output int cnt);
        logic prev;
        prev = outputEnable;
        cnt = 0;
        repeat (win) begin
            @(negedge clk);
            if (!prev && outputEnable) cnt++;
            prev = outputEnable;
        end
    endtask : countRises
    // Off then on, by command or by pin, clears a latched fault
    task automatic offOn(input bit pin);
        int n;
        if (pin) controlPin = 1'b0;
        else operationOn = 1'b0;
        cyc(3);
        temperature = WARM;
        controlPin = 1'b1;
        operationOn = 1'b1;
        nextRise(n);
    endtask : offOn

    // ********************************
    // Scenarios
    // ********************************
    task automatic test_regs();
        ttfr_rsp_t r;
        logic [7:0] cmds [4];
        logic [15:0] vals [4];
        cmds = '{CMD_OT_WARN, CMD_UT_WARN, CMD_UT_FAULT, CMD_UT_ACTION};
        vals = '{16'h0028, 16'h0018, 16'h0010, 16'hffc3};
        for (int i = 0; i < 4; i++) begin
            host_u.access(1'b0, cmds[i], 16'h0000, r);
            check("reset value", r.rdata, 16'h0000);
            host_u.access(1'b1, cmds[i], vals[i], r);
            host_u.access(1'b0, cmds[i], 16'h0000, r);
            check("rvalid", 16'(r.rvalid), 16'h0001);
            check("read back", r.rdata, i == 3 ? 16'h00c3 : vals[i]);
        end
        host_u.access(1'b0, 8'h55, 16'h0000, r);
        check("unknown", 16'(r.unknown), 16'h0001);
        setAct(8'h00);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_warn();
        pulse(clearWarnBits);
        temperature = 16'h0014;
        cyc(3);
        check("ut warn", 16'(utWarnFlag), 16'h0001);
        check("ot quiet", 16'(otWarnFlag), 16'h0000);
        check("warn runs", 16'(outputEnable), 16'h0001);
        temperature = 16'h0032;
        cyc(3);
        check("ot warn", 16'(otWarnFlag), 16'h0001);
        temperature = WARM;
        pulse(clearWarnBits);
        cyc(1);
        check("warn clr", 16'({utWarnFlag, otWarnFlag}), 16'h0000);
        temperature = COLD;
        cyc(5);
        check("fault flag", 16'(utFaultFlag), 16'h0001);
        check("ignore runs", 16'(outputEnable), 16'h0001);
        temperature = WARM;
        pulse(clearAll);
        cyc(1);
        check("flag clr", 16'(utFaultFlag), 16'h0000);
        $display("test_warn done");
    endtask : test_warn
    task automatic test_latch();
        int n;
        setAct(8'hc0);
        temperature = COLD;
        cyc(2);
        check("latch off", 16'(outputEnable), 16'h0000);
        temperature = WARM;
        cyc(50);
        check("latch held", 16'(outputEnable), 16'h0000);
        pulse(clearFaultBit);
        nextRise(n);
        temperature = COLD;
        cyc(2);
        temperature = WARM;
        pulse(clearAll);
        nextRise(n);
        temperature = COLD;
        cyc(2);
        offOn(1'b0);
        pulse(clearAll);
        $display("test_latch done");
    endtask : test_latch
    task automatic test_retries();
        int cnt;
        unitCycles = 2;
        for (int n = 0; n < 7; n++) begin
            setAct({2'b10, 3'(n), 3'b000});
            temperature = COLD;
            countRises(120, cnt);
            check("restarts", 16'(cnt), 16'(n));
            check("then off", 16'(outputEnable), 16'h0000);
            temperature = WARM;
            pulse(clearAll);
            nextRise(cnt);
        end
        setAct(8'hb8);
        temperature = COLD;
        countRises(120, cnt);
        check("endless", 16'(cnt > 6), 16'h0001);
        otherFault = 1'b1;
        cyc(3);
        countRises(60, cnt);
        check("other stops", 16'(cnt), 16'h0000);
        otherFault = 1'b0;
        offOn(1'b1);
        $display("test_retries done");
    endtask : test_retries
    // Constant overhead cancels in the difference of two spacings
    task automatic test_spacing();
        int g [2];
        int n;
        unitCycles = 3;
        for (int c = 2; c < 4; c++) begin
            setAct({5'b10111, 3'(c)});
            temperature = COLD;
            nextRise(n);
            nextRise(g[c-2]);
            offOn(1'b0);
        end
        check("spacing", 16'(g[1] - g[0]), 16'd12);
        $display("test_spacing done");
    endtask : test_spacing
    task automatic test_continue();
        int n;
        unitCycles = 2;
        setAct(8'h44);
        temperature = COLD;
        cyc(28);
        check("runs on", 16'(outputEnable), 16'h0001);
        cyc(10);
        check("then off", 16'(outputEnable), 16'h0000);
        temperature = WARM;
        cyc(20);
        check("no retry", 16'(outputEnable), 16'h0000);
        pulse(clearAll);
        nextRise(n);
        $display("test_continue done");
    endtask : test_continue

    // Clock and main sequence
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        temperature = WARM;
        unitCycles = 2;
        clearAll = 1'b0;
        clearFaultBit = 1'b0;
        clearWarnBits = 1'b0;
        operationOn = 1'b1;
        controlPin = 1'b1;
        otherFault = 1'b0;
        fails = 0;
        num_checks = 0;
        cyc(3);
        rstn = 1'b1;
        test_regs();
        test_warn();
        test_latch();
        test_retries();
        test_spacing();
        test_continue();
        summarize();
    end
endmodule : ttfr_fault_resp_tb
